// *** include/qga_pkg.sv ***
// Constants and types shared by the gain/phase correction register block
package qga_pkg;

  localparam int AW         = 5;
  localparam int DW         = 8;
  localparam int SW         = 16;
  localparam int GAIN_W     = 11;
  localparam int PHASE_W    = 10;
  localparam int GAIN_FRAC  = 10;
  localparam int PHASE_FRAC = 12;

  localparam logic [AW-1:0] ADDR_RSVD      = 5'h1a;
  localparam logic [AW-1:0] ADDR_GAIN_A_LO = 5'h1b;
  localparam logic [AW-1:0] ADDR_GAIN_B_LO = 5'h1c;
  localparam logic [AW-1:0] ADDR_PHASE_LO  = 5'h1d;
  localparam logic [AW-1:0] ADDR_UPPER     = 5'h1e;
  localparam logic [AW-1:0] ADDR_ALARM_REV = 5'h1f;

  localparam logic [DW-1:0] RST_GAIN_A_LO = 8'h00;
  localparam logic [DW-1:0] RST_GAIN_B_LO = 8'h00;
  localparam logic [DW-1:0] RST_PHASE_LO  = 8'h00;
  localparam logic [DW-1:0] RST_UPPER     = 8'h24;
  localparam logic [DW-1:0] RD_ZERO       = 8'h00;

  // Upper-bits register layout
  localparam int PH_HI_MSB = 7;
  localparam int PH_HI_LSB = 6;
  localparam int GA_HI_MSB = 5;
  localparam int GA_HI_LSB = 3;
  localparam int GB_HI_MSB = 2;
  localparam int GB_HI_LSB = 0;

  // Alarm and revision register layout
  localparam int ALARM_BIT = 7;
  localparam int MUTE_BIT  = 6;
  localparam int VER_MSB   = 5;
  localparam int VER_W     = 6;

  // Arbitrary revision value
  localparam logic [VER_W-1:0] CHIP_VERSION = 6'h2a;

  localparam logic [GAIN_W-1:0]  GAIN_UNITY = 11'h400;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 10'h000;

  localparam logic [SW-1:0] MID_LEVEL = 16'h0000;
  localparam logic [SW-1:0] SAT_POS   = 16'h7fff;
  localparam logic [SW-1:0] SAT_NEG   = 16'h8000;

  // Input sample clock is declared stopped after this many device clocks
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_STOP_CYC  = 4;
  localparam int STOP_CNT_W    = 3;

  typedef logic [SW-1:0] qga_sample_t;

  typedef enum logic [1:0] {
    MON_RUN  = 2'b01,
    MON_STOP = 2'b10
  } qga_mon_e;

endpackage : qga_pkg

// *** include/qga_mon_if.sv ***
// Event path from the sample clock monitor to the register core
interface qga_mon_if;
  logic stop_evt;

  modport mon  (output stop_evt);
  modport core (input  stop_evt);
endinterface : qga_mon_if

// *** logic/qga_clk_mon.sv ***
// Loss detector for the double-data-rate input sample clock
module qga_clk_mon (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic input_sample_clock,
  qga_mon_if.mon    mon
);
  import qga_pkg::*;

  logic                  sync1_q;
  logic                  sync2_q;
  logic                  sync3_q;
  logic [STOP_CNT_W-1:0] idle_cnt_q;
  logic [STOP_CNT_W-1:0] idle_cnt_d;
  qga_mon_e              state_q;
  qga_mon_e              state_d;
  logic                  stop_q;
  logic                  any_edge;
  logic                  stop_hit;

  localparam logic [STOP_CNT_W-1:0] STOP_LAST = STOP_CNT_W'(CLK_STOP_CYC - 1);
  localparam logic [STOP_CNT_W-1:0] CNT_ONE   = STOP_CNT_W'(1);

  // Both edges count as activity, the clock is double data rate
  assign any_edge   = sync2_q ^ sync3_q;
  assign stop_hit   = !any_edge && (idle_cnt_q == STOP_LAST);
  assign idle_cnt_d = any_edge ? '0 : (stop_hit ? idle_cnt_q : idle_cnt_q + CNT_ONE);

  always_comb begin
    case (state_q)
      MON_RUN:  state_d = stop_hit ? MON_STOP : MON_RUN;
      MON_STOP: state_d = any_edge ? MON_RUN : MON_STOP;
      default:  state_d = MON_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= input_sample_clock;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_q <= '0;
      state_q    <= MON_RUN;
      stop_q     <= 1'b0;
    end else if (ce) begin
      idle_cnt_q <= idle_cnt_d;
      state_q    <= state_d;
      stop_q     <= (state_q == MON_RUN) && stop_hit;
    end
  end

  assign mon.stop_evt = stop_q;

  property p_stop_single;
    @(posedge clk) disable iff (rst)
      (stop_q && ce) |=> !stop_q;
  endproperty
  a_stop_single: assert property (p_stop_single) else $error("stop event longer than one cycle");

endmodule : qga_clk_mon

// *** logic/qga_core.sv ***
// Gain and phase correction registers, shadow commit, clock-loss alarm and mute
module qga_core (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   input_sample_clock,
  input  wire logic [qga_pkg::AW-1:0] reg_addr,
  input  wire logic [qga_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [qga_pkg::DW-1:0] reg_rdata,
  input  wire qga_pkg::qga_sample_t   i_sample,
  input  wire qga_pkg::qga_sample_t   q_sample,
  input  wire logic                   sample_valid,
  output qga_pkg::qga_sample_t        dac_a_out,
  output qga_pkg::qga_sample_t        dac_b_out,
  output logic                        out_valid
);
  import qga_pkg::*;

  // Staged register contents
  logic [DW-1:0]      gain_a_lo_q;
  logic [DW-1:0]      gain_b_lo_q;
  logic [DW-1:0]      phase_lo_q;
  logic [DW-1:0]      upper_q;
  logic [DW-1:0]      upper_d;
  // Active correction settings
  logic [GAIN_W-1:0]  gain_a_act_q;
  logic [GAIN_W-1:0]  gain_b_act_q;
  logic [PHASE_W-1:0] phase_act_q;
  logic [GAIN_W-1:0]  gain_a_stage;
  logic [GAIN_W-1:0]  gain_b_stage;
  logic [PHASE_W-1:0] phase_stage;
  logic               alarm_q;
  logic               alarm_d;
  logic               mute_q;
  logic               mute_d;
  logic [DW-1:0]      rdata_q;
  logic [DW-1:0]      rdata_d;
  qga_sample_t        dac_a_q;
  qga_sample_t        dac_b_q;
  qga_sample_t        dac_a_d;
  qga_sample_t        dac_b_d;
  logic               valid_q;

  logic               wr_fire;
  logic               wr_gain_a;
  logic               wr_gain_b;
  logic               wr_phase;
  logic               wr_upper;
  logic               wr_alarm;
  logic               sync_evt;
  logic               stop_evt;
  logic signed [25:0] ph_prod;
  logic signed [25:0] ph_sum;
  logic signed [16:0] corr_i;
  logic signed [16:0] q_ext;

  qga_mon_if mon_bus ();

  qga_clk_mon u_clk_mon (
    .clk                (clk),
    .rst                (rst),
    .ce                 (ce),
    .input_sample_clock (input_sample_clock),
    .mon                (mon_bus.mon)
  );

  assign stop_evt = mon_bus.stop_evt;

  // Gain is 1.10 unsigned; the product is rounded toward minus infinity and clipped
  function automatic qga_sample_t scale_gain(input logic signed [16:0] x,
                                             input logic [GAIN_W-1:0] g);
    logic signed [28:0] prod;
    logic signed [28:0] sh;
    prod = x * $signed({1'b0, g});
    sh   = prod >>> GAIN_FRAC;
    if (sh > $signed({{13{1'b0}}, SAT_POS})) begin
      scale_gain = SAT_POS;
    end else if (sh < $signed({{13{1'b1}}, SAT_NEG})) begin
      scale_gain = SAT_NEG;
    end else begin
      scale_gain = sh[SW-1:0];
    end
  endfunction : scale_gain

  // Register decode
  assign wr_fire   = reg_wr && ce;
  assign wr_gain_a = wr_fire && (reg_addr == ADDR_GAIN_A_LO);
  assign wr_gain_b = wr_fire && (reg_addr == ADDR_GAIN_B_LO);
  assign wr_phase  = wr_fire && (reg_addr == ADDR_PHASE_LO);
  assign wr_upper  = wr_fire && (reg_addr == ADDR_UPPER);
  assign wr_alarm  = wr_fire && (reg_addr == ADDR_ALARM_REV);
  assign sync_evt  = wr_gain_a;

  assign upper_d = wr_upper ? reg_wdata : upper_q;

  // Staged words as they stand after this cycle's write
  assign gain_a_stage = {upper_d[GA_HI_MSB:GA_HI_LSB], reg_wdata};
  assign gain_b_stage = {upper_d[GB_HI_MSB:GB_HI_LSB],
                         (wr_gain_b ? reg_wdata : gain_b_lo_q)};
  assign phase_stage  = {upper_d[PH_HI_MSB:PH_HI_LSB],
                         (wr_phase ? reg_wdata : phase_lo_q)};

  // Set wins over a simultaneous clear; writing one keeps the flag
  assign alarm_d = stop_evt || (alarm_q && !(wr_alarm && !reg_wdata[ALARM_BIT]));
  assign mute_d  = stop_evt || (mute_q && !(wr_alarm && !reg_wdata[MUTE_BIT]));

  always_comb begin
    case (reg_addr)
      ADDR_GAIN_A_LO: rdata_d = gain_a_lo_q;
      ADDR_GAIN_B_LO: rdata_d = gain_b_lo_q;
      ADDR_PHASE_LO:  rdata_d = phase_lo_q;
      ADDR_UPPER:     rdata_d = upper_q;
      ADDR_ALARM_REV: rdata_d = {alarm_q, mute_q, CHIP_VERSION};
      default:        rdata_d = RD_ZERO;
    endcase
  end

  // Phase is s.12 fraction of Q, added into I before gain
  assign q_ext   = {q_sample[SW-1], q_sample};
  assign ph_prod = $signed(q_sample) * $signed(phase_act_q);
  assign ph_sum  = (ph_prod >>> PHASE_FRAC) + 26'($signed(i_sample));
  assign corr_i  = ph_sum[16:0];

  assign dac_a_d = mute_q ? MID_LEVEL : scale_gain(corr_i, gain_a_act_q);
  assign dac_b_d = mute_q ? MID_LEVEL : scale_gain(q_ext, gain_b_act_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_a_lo_q <= RST_GAIN_A_LO;
      gain_b_lo_q <= RST_GAIN_B_LO;
      phase_lo_q  <= RST_PHASE_LO;
      upper_q     <= RST_UPPER;
    end else begin
      if (wr_gain_a) gain_a_lo_q <= reg_wdata;
      if (wr_gain_b) gain_b_lo_q <= reg_wdata;
      if (wr_phase)  phase_lo_q  <= reg_wdata;
      if (wr_upper)  upper_q     <= reg_wdata;
    end
  end

  // Active settings move only on a synchronization event
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_a_act_q <= GAIN_UNITY;
      gain_b_act_q <= GAIN_UNITY;
      phase_act_q  <= PHASE_ZERO;
    end else if (sync_evt) begin
      gain_a_act_q <= gain_a_stage;
      gain_b_act_q <= gain_b_stage;
      phase_act_q  <= phase_stage;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_q <= 1'b0;
      mute_q  <= 1'b0;
      rdata_q <= RD_ZERO;
    end else if (ce) begin
      alarm_q <= alarm_d;
      mute_q  <= mute_d;
      if (reg_rd) rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dac_a_q <= MID_LEVEL;
      dac_b_q <= MID_LEVEL;
      valid_q <= 1'b0;
    end else if (ce) begin
      valid_q <= sample_valid;
      // Refreshed while muted so mid-level shows even when no samples arrive
      if (sample_valid || mute_q) begin
        dac_a_q <= dac_a_d;
        dac_b_q <= dac_b_d;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign dac_a_out = dac_a_q;
  assign dac_b_out = dac_b_q;
  assign out_valid = valid_q;

  property p_sync_load;
    @(posedge clk) disable iff (rst)
      wr_gain_a |=> (gain_a_act_q[DW-1:0] == $past(reg_wdata))
                 && (gain_b_act_q[DW-1:0] == gain_b_lo_q)
                 && (phase_act_q[DW-1:0] == phase_lo_q);
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("staged values not committed");

  property p_no_early_commit;
    @(posedge clk) disable iff (rst)
      (!wr_gain_a && (wr_gain_b || wr_phase || wr_upper))
        |=> $stable(gain_a_act_q) && $stable(gain_b_act_q) && $stable(phase_act_q);
  endproperty
  a_no_early_commit: assert property (p_no_early_commit) else $error("active changed early");

  property p_reset_unity;
    @(posedge clk)
      $past(rst) |-> (gain_a_act_q == GAIN_UNITY) && (gain_b_act_q == GAIN_UNITY)
                     && (upper_q == RST_UPPER);
  endproperty
  a_reset_unity: assert property (p_reset_unity) else $error("gain not unity after reset");

  property p_mute_mid;
    @(posedge clk) disable iff (rst)
      (ce && sample_valid && mute_q) |=> (dac_a_q == MID_LEVEL) && (dac_b_q == MID_LEVEL);
  endproperty
  a_mute_mid: assert property (p_mute_mid) else $error("muted output not mid-level");

  property p_stop_sets_flags;
    @(posedge clk) disable iff (rst)
      (ce && stop_evt) |=> alarm_q && mute_q;
  endproperty
  a_stop_sets_flags: assert property (p_stop_sets_flags) else $error("alarm flags not set");

  property p_write_one_keeps;
    @(posedge clk) disable iff (rst)
      (wr_alarm && reg_wdata[ALARM_BIT] && alarm_q) |=> alarm_q;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("write one altered alarm");

  property p_zero_clears;
    @(posedge clk) disable iff (rst)
      (wr_alarm && !reg_wdata[ALARM_BIT] && !reg_wdata[MUTE_BIT] && !stop_evt)
        |=> !alarm_q && !mute_q;
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("zero write did not clear");

  property p_version_ro;
    @(posedge clk) disable iff (rst)
      (ce && reg_rd && reg_addr == ADDR_ALARM_REV)
        |=> reg_rdata[VER_MSB:0] == CHIP_VERSION;
  endproperty
  a_version_ro: assert property (p_version_ro) else $error("version field wrong");

  property p_unity_pass;
    @(posedge clk) disable iff (rst)
      (ce && sample_valid && !mute_q && gain_a_act_q == GAIN_UNITY
       && gain_b_act_q == GAIN_UNITY && phase_act_q == PHASE_ZERO)
        |=> (dac_a_q == $past(i_sample)) && (dac_b_q == $past(q_sample));
  endproperty
  a_unity_pass: assert property (p_unity_pass) else $error("unity gain altered sample");

  property p_sync_upper;
    @(posedge clk) disable iff (rst)
      wr_gain_a |=> (gain_a_act_q[GAIN_W-1:DW] == upper_q[GA_HI_MSB:GA_HI_LSB])
                 && (gain_b_act_q[GAIN_W-1:DW] == upper_q[GB_HI_MSB:GB_HI_LSB])
                 && (phase_act_q[PHASE_W-1:DW] == upper_q[PH_HI_MSB:PH_HI_LSB]);
  endproperty
  a_sync_upper: assert property (p_sync_upper) else $error("upper bits not committed");

  property p_upper_store;
    @(posedge clk) disable iff (rst)
      wr_upper |=> (upper_q == $past(reg_wdata));
  endproperty
  a_upper_store: assert property (p_upper_store) else $error("upper register not stored");

  property p_gain_b_store;
    @(posedge clk) disable iff (rst)
      wr_gain_b |=> (gain_b_lo_q == $past(reg_wdata));
  endproperty
  a_gain_b_store: assert property (p_gain_b_store) else $error("gain B byte not stored");

  property p_alarm_sticky;
    @(posedge clk) disable iff (rst)
      (alarm_q && !wr_alarm) |=> alarm_q;
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm dropped by itself");

  property p_mute_sticky;
    @(posedge clk) disable iff (rst)
      (mute_q && !wr_alarm) |=> mute_q;
  endproperty
  a_mute_sticky: assert property (p_mute_sticky) else $error("mute dropped by itself");

  property p_no_false_alarm;
    @(posedge clk) disable iff (rst)
      (!alarm_q && !stop_evt) |=> !alarm_q;
  endproperty
  a_no_false_alarm: assert property (p_no_false_alarm) else $error("alarm without stop");

  property p_mute_force;
    @(posedge clk) disable iff (rst)
      (ce && mute_q) |=> (dac_a_q == MID_LEVEL) && (dac_b_q == MID_LEVEL);
  endproperty
  a_mute_force: assert property (p_mute_force) else $error("mute did not force mid-level");

  property p_reset_phase;
    @(posedge clk)
      $past(rst) |-> (phase_act_q == PHASE_ZERO) && (phase_lo_q == RST_PHASE_LO)
                     && !alarm_q && !mute_q;
  endproperty
  a_reset_phase: assert property (p_reset_phase) else $error("phase not zero after reset");

  property p_gain_b_unity;
    @(posedge clk) disable iff (rst)
      (ce && sample_valid && !mute_q && gain_b_act_q == GAIN_UNITY)
        |=> (dac_b_q == $past(q_sample));
  endproperty
  a_gain_b_unity: assert property (p_gain_b_unity) else $error("unity gain B altered Q");

  property p_sat_pos;
    @(posedge clk) disable iff (rst)
      (ce && sample_valid && !mute_q && q_sample == SAT_POS && gain_b_act_q > GAIN_UNITY)
        |=> (dac_b_q == SAT_POS);
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("gain B output not clipped");

  property p_sat_neg;
    @(posedge clk) disable iff (rst)
      (ce && sample_valid && !mute_q && i_sample == SAT_NEG && phase_act_q == PHASE_ZERO
       && gain_a_act_q > GAIN_UNITY) |=> (dac_a_q == SAT_NEG);
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("gain A output not clipped");

  property p_read_flags;
    @(posedge clk) disable iff (rst)
      (ce && reg_rd && reg_addr == ADDR_ALARM_REV)
        |=> (reg_rdata[ALARM_BIT] == $past(alarm_q)) && (reg_rdata[MUTE_BIT] == $past(mute_q));
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag readback wrong");

endmodule : qga_core

// *** tb/qmc_gain_phase_clock_alarm_tb.sv ***
// Self-checking bench for the gain, phase and clock-alarm register block
module qmc_gain_phase_clock_alarm_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import qga_pkg::*;

  logic              clk;
  logic              rst;
  logic              ce;
  logic              input_sample_clock;
  logic [AW-1:0]     reg_addr;
  logic [DW-1:0]     reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DW-1:0]     reg_rdata;
  qga_sample_t       i_sample;
  qga_sample_t       q_sample;
  logic              sample_valid;
  qga_sample_t       dac_a_out;
  qga_sample_t       dac_b_out;
  logic              out_valid;
  logic              sclk_run;
  int                tcnt;
  int                cycles;
  int                miscompares;
  int                compares;

  qga_core dut_u (
    .clk                (clk),
    .rst                (rst),
    .ce                 (ce),
    .input_sample_clock (input_sample_clock),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .i_sample           (i_sample),
    .q_sample           (q_sample),
    .sample_valid       (sample_valid),
    .dac_a_out          (dac_a_out),
    .dac_b_out          (dac_b_out),
    .out_valid          (out_valid)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Sample clock toggles every 3 device clocks, so only both edges keep it alive
  always @(posedge clk) begin
    #1;
    if (sclk_run) begin
      tcnt = tcnt + 1;
      if (tcnt == 3) begin
        tcnt = 0;
        input_sample_clock = ~input_sample_clock;
      end
    end
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd

  task automatic rd_chk(input string name, input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    rd(a, d);
    chk(name, {8'h00, e}, {8'h00, d});
  endtask : rd_chk

  task automatic smp_chk(input qga_sample_t i, input qga_sample_t q,
                         input qga_sample_t ea, input qga_sample_t eb);
    @(posedge clk);
    #1;
    i_sample     = i;
    q_sample     = q;
    sample_valid = 1'b1;
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
    chk("out_valid", 16'h0001, {15'h0000, out_valid});
    chk("dac_a_out", ea, dac_a_out);
    chk("dac_b_out", eb, dac_b_out);
  endtask : smp_chk

  task automatic t_reset_values();
    rd_chk("gain_a_low_byte", ADDR_GAIN_A_LO, 8'h00);
    rd_chk("gain_b_low_byte", ADDR_GAIN_B_LO, 8'h00);
    rd_chk("phase_low_byte", ADDR_PHASE_LO, 8'h00);
    rd_chk("gain_phase_upper_bits", ADDR_UPPER, 8'h24);
    rd_chk("alarm_and_chip_revision", ADDR_ALARM_REV, {2'b00, CHIP_VERSION});
    smp_chk(16'h1234, 16'hf00d, 16'h1234, 16'hf00d);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_unmapped();
    rd_chk("unmapped", 5'h05, 8'h00);
    wr(ADDR_RSVD, 8'hff);
    rd_chk("factory_reserved_1a", ADDR_RSVD, 8'h00);
    ce = 1'b0;
    wr(ADDR_GAIN_B_LO, 8'h11);
    ce = 1'b1;
    rd_chk("gain_b_low_byte", ADDR_GAIN_B_LO, 8'h00);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_commit();
    // Gain A 0x200, gain B 0x680, phase 0x100 staged through the shared register
    wr(ADDR_UPPER, 8'h56);
    wr(ADDR_GAIN_B_LO, 8'h80);
    wr(ADDR_PHASE_LO, 8'h00);
    rd_chk("gain_phase_upper_bits", ADDR_UPPER, 8'h56);
    smp_chk(16'h0100, 16'h0400, 16'h0100, 16'h0400);
    wr(ADDR_GAIN_A_LO, 8'h00);
    smp_chk(16'h0100, 16'h0400, 16'h00a0, 16'h0680);
    // Negative phase 0x300 and gain A 0x401, gain B keeps its low byte
    wr(ADDR_UPPER, 8'he4);
    smp_chk(16'h4000, 16'h0400, 16'h2020, 16'h0680);
    wr(ADDR_GAIN_A_LO, 8'h01);
    smp_chk(16'h4000, 16'h0400, 16'h3fcf, 16'h0480);
    $display("test commit done");
  endtask : t_commit

  task automatic t_alarm();
    logic [DW-1:0] d;
    int            n;
    rd_chk("alarm_and_chip_revision", ADDR_ALARM_REV, 8'h2a);
    sclk_run = 1'b0;
    n        = 0;
    d        = 8'h00;
    while (d[7] !== 1'b1 && n < 15) begin
      rd(ADDR_ALARM_REV, d);
      n = n + 1;
    end
    chk("alarm_latency_ok", 16'h0001, {15'h0000, (n >= 2 && n <= 8)});
    chk("alarm_and_chip_revision", 16'h00ea, {8'h00, d});
    chk("dac_a_out", MID_LEVEL, dac_a_out);
    smp_chk(16'h4000, 16'h0400, MID_LEVEL, MID_LEVEL);
    wr(ADDR_ALARM_REV, 8'hff);
    rd_chk("alarm_and_chip_revision", ADDR_ALARM_REV, 8'hea);
    wr(ADDR_ALARM_REV, 8'h40);
    rd_chk("alarm_and_chip_revision", ADDR_ALARM_REV, 8'h6a);
    smp_chk(16'h4000, 16'h0400, MID_LEVEL, MID_LEVEL);
    wr(ADDR_ALARM_REV, 8'h00);
    rd_chk("alarm_and_chip_revision", ADDR_ALARM_REV, 8'h2a);
    smp_chk(16'h4000, 16'h0400, 16'h3fcf, 16'h0480);
    sclk_run = 1'b1;
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_saturate();
    // Gain A 0x7ff, gain B 0x780, phase zero: largest gain A, then clipping
    wr(ADDR_UPPER, 8'h3f);
    wr(ADDR_GAIN_A_LO, 8'hff);
    smp_chk(16'h4000, 16'h0400, 16'h7ff0, 16'h0780);
    smp_chk(SAT_NEG, SAT_POS, SAT_NEG, SAT_POS);
    @(posedge clk);
    #1;
    chk("out_valid", 16'h0000, {15'h0000, out_valid});
    chk("dac_a_out", SAT_NEG, dac_a_out);
    $display("test saturate done");
  endtask : t_saturate

  initial begin
    rst                = 1'b1;
    ce                 = 1'b1;
    input_sample_clock = 1'b0;
    reg_addr           = 5'h00;
    reg_wdata          = 8'h00;
    reg_wr             = 1'b0;
    reg_rd             = 1'b0;
    i_sample           = 16'h0000;
    q_sample           = 16'h0000;
    sample_valid       = 1'b0;
    sclk_run           = 1'b1;
    tcnt               = 0;
    cycles             = 0;
    miscompares        = 0;
    compares           = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset_values();
    t_unmapped();
    t_commit();
    t_alarm();
    t_saturate();
    close_out();
  end

endmodule : qmc_gain_phase_clock_alarm_tb
